// >>> shared/bcdr_pkg.sv
// Package for the bridge control and diagnostic register bank.
// Assumes a 10 MHz core clock and 32-bit configuration-space access.
package bcdr_pkg;

  // Configuration-space byte offsets of the two registers.
  localparam logic [7:0] BCDR_DIAG0_OFS = 8'hC0;
  localparam logic [7:0] BCDR_DIAG1_OFS = 8'hC4;

  // Reset values.
  localparam logic [31:0] BCDR_DIAG0_RST = 32'h00000000;
  localparam logic [31:0] BCDR_DIAG1_RST = 32'h00120108;

  // Writable bits of each register.
  localparam logic [31:0] BCDR_DIAG0_WMASK = 32'h000300FE;
  localparam logic [31:0] BCDR_DIAG1_WMASK = 32'h001FFFFF;

  // Bits cleared by the fundamental reset and by the global reset.
  localparam logic [31:0] BCDR_DIAG0_FUNDAMENTAL_RESET_N_MASK = 32'h0000007E;
  localparam logic [31:0] BCDR_DIAG0_GLOBAL_RESET_N_MASK = 32'h00030000;
  localparam logic [31:0] BCDR_DIAG1_FUNDAMENTAL_RESET_N_MASK = 32'h001FFFFF;

  // Threshold extras in doublewords and line multipliers.
  localparam logic [9:0] BCDR_THR_EXTRA_4 = 10'h004;
  localparam logic [9:0] BCDR_THR_EXTRA_8 = 10'h008;
  localparam logic [9:0] BCDR_THR_EXTRA_12 = 10'h00C;
  localparam logic [1:0] BCDR_THR_1LINE = 2'h1;
  localparam logic [1:0] BCDR_THR_2LINE = 2'h2;

  // Cache line sizes in doublewords.
  localparam logic [7:0] BCDR_CL_DEFAULT_DW = 8'h08;
  localparam logic [7:0] BCDR_CL_VALID_A = 8'h08;
  localparam logic [7:0] BCDR_CL_VALID_B = 8'h10;
  localparam logic [7:0] BCDR_CL_VALID_C = 8'h20;
  localparam logic [7:0] BCDR_SINGLE_DW = 8'h01;

  // Entry timer tick lengths, in picoseconds and in clock cycles.
  localparam int BCDR_CLK_PERIOD_PS = 100000;
  localparam int BCDR_L1_TICK_PS = 512000;
  localparam int BCDR_L0S_TICK_PS = 16000;
  localparam int BCDR_L1_TICK_RAW =
    (BCDR_L1_TICK_PS + BCDR_CLK_PERIOD_PS - 1) / BCDR_CLK_PERIOD_PS;
  localparam int BCDR_L0S_TICK_RAW =
    (BCDR_L0S_TICK_PS + BCDR_CLK_PERIOD_PS - 1) / BCDR_CLK_PERIOD_PS;
  localparam logic [2:0] BCDR_L1_TICK_CYC =
    3'((BCDR_L1_TICK_RAW < 1) ? 1 : BCDR_L1_TICK_RAW);
  localparam logic [2:0] BCDR_L0S_TICK_CYC =
    3'((BCDR_L0S_TICK_RAW < 1) ? 1 : BCDR_L0S_TICK_RAW);

  // Layout of the first diagnostic register (all 32 bits).
  typedef struct packed {
    logic [13:0] zero_hi;
    logic dis_bridge_pme;
    logic dis_ohci_pme;
    logic [7:0] zero_mid;
    logic cl_check_en;
    logic four_line_prefetch;
    logic [1:0] up_thresh;
    logic up_thresh_en;
    logic cfg_mem_access;
    logic rsvd1;
    logic zero0;
  } bcdr_diag0_t;

  // Layout of the second diagnostic register.
  typedef struct packed {
    logic [10:0] zero_hi;
    logic [2:0] l1_exit_async;
    logic [2:0] l1_exit_common;
    logic [3:0] rsvd_hi;
    logic secondary_reset_mask;
    logic [3:0] l1_entry_timer;
    logic [3:0] l0s_entry_timer;
    logic [1:0] rsvd_lo;
  } bcdr_diag1_t;

  // One configuration-space access request.
  typedef struct packed {
    logic req;
    logic we;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } bcdr_cfg_req_t;

endpackage

// >>> design/bcdr_regs.sv
// Bridge control and diagnostic register bank with prefetch sizing,
// upstream threshold gating, latency mirroring and link entry timers.
// Assumes configuration accesses and bridge status come from the core
// clock domain; only the two reset pins arrive asynchronously.
//
// Functional notes
// - Four-line prefetch plus forced multiple read prefetch four lines on all reads.
// - Read prefetch disable overrides four-line prefetch; burst reads fetch one doubleword.
// - Four-line prefetch acts only while cache-line checking is enabled.
// - Threshold field selects one line plus 4, 8, 12 DW or two lines plus 4.
// - With bit 3 set, upstream transactions are accepted only when the selected space is free.
// - An invalid cache line size counts as eight doublewords for the threshold.
// - Bit 3 enables threshold mode; disabled after reset.
// - Bit 2 lets configuration accesses reach memory-mapped configuration registers.
// - Bit 0 of the first register is read-only zero.
// - Fundamental-reset fields clear when the PCIe or global reset is low.
// - Global-class fields clear only on global reset or power-on reset.
// - Bits 31 to 21 of the second register read as zero.
// - With common clock set, the asynchronous exit latency feeds link capabilities.
// - With common clock clear, the common exit latency feeds link capabilities.
// - Bit 10 masks the secondary bus reset requested by bridge control.
// - L1 entry timer counts 512 ns ticks, default four; here each tick is 6 clock cycles (600 ns).
// - L0s entry timer counts 62.5 MHz ticks, default two; here each tick is one 100 ns clock cycle.
`timescale 1ns/1ns

module bcdr_regs
  import bcdr_pkg::*;
(
  // Clock and resets.
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_pcie_rst_b,
  input wire logic i_global_reset_n,

  // Configuration-space access.
  input wire bcdr_cfg_req_t i_cfg,
  output logic [31:0] o_cfg_rdata,
  output logic o_cfg_ack,

  // Upstream read prefetch sizing.
  input wire logic i_force_multiple_read,
  input wire logic i_read_prefetch_disable,
  input wire logic i_read_multiple,
  input wire logic i_burst_read,
  input wire logic [7:0] i_cache_line_size,
  output logic [7:0] o_prefetch_dw,

  // Upstream request acceptance.
  input wire logic i_up_req,
  input wire logic [9:0] i_buf_free_dw,
  output logic o_up_accept,

  // Configuration access to memory-mapped registers.
  output logic o_cfg_mem_access_en,

  // Link capabilities mirror.
  input wire logic i_common_clock_config,
  output logic [2:0] o_link_cap_l1_exit,

  // Secondary bus reset.
  input wire logic i_secondary_reset_request,
  output logic o_secondary_reset,

  // Power management disables.
  output logic o_dis_bridge_pme,
  output logic o_dis_ohci_pme,

  // Active-state link entry timers.
  input wire logic i_link_activity,
  output logic o_l1_entry_req,
  output logic o_l0s_entry_req
);

  logic perst_s1_reg;
  logic perst_s2_reg;
  logic global_reset_n_s1_reg;
  logic global_reset_n_s2_reg;
  logic fundamental_reset_n_active;
  logic global_reset_n_active;
  bcdr_diag0_t diag0_reg;
  bcdr_diag0_t diag0_next;
  bcdr_diag1_t diag1_reg;
  bcdr_diag1_t diag1_next;
  logic hit0;
  logic hit1;
  logic rd_strobe;
  logic [31:0] rdata_next;
  logic [7:0] cl_dw;
  logic [9:0] need_dw;
  logic [7:0] prefetch_next;
  logic [3:0] tmr_limit [2];
  logic [2:0] tmr_tick_len [2];
  logic tmr_req [2];

  // Applies byte enables and the writable mask to a register write.
  function automatic logic [31:0] be_write(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be,
                                           input logic [31:0] wmask);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    return (old_v & ~m) | (new_v & m);
  endfunction

  // Cache line length in doublewords, eight when the size is invalid.
  function automatic logic [7:0] line_dw(input logic [7:0] size);
    if ((size == BCDR_CL_VALID_A) || (size == BCDR_CL_VALID_B) ||
        (size == BCDR_CL_VALID_C)) begin
      return size;
    end
    return BCDR_CL_DEFAULT_DW;
  endfunction

  // Forces the masked bits back to their reset values.
  function automatic logic [31:0] reset_fields(input logic [31:0] cur,
                                               input logic [31:0] rst_v,
                                               input logic [31:0] mask);
    return (cur & ~mask) | (rst_v & mask);
  endfunction

  // Matches a live configuration request against one register offset.
  function automatic logic cfg_hit(input bcdr_cfg_req_t req,
                                   input logic [7:0] ofs);
    return req.req && (req.addr == ofs);
  endfunction

  // Synchronises the reset pins into the core clock domain.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      perst_s1_reg <= 1'b0;
      perst_s2_reg <= 1'b0;
      global_reset_n_s1_reg <= 1'b0;
      global_reset_n_s2_reg <= 1'b0;
    end else begin
      perst_s1_reg <= i_pcie_rst_b;
      perst_s2_reg <= perst_s1_reg;
      global_reset_n_s1_reg <= i_global_reset_n;
      global_reset_n_s2_reg <= global_reset_n_s1_reg;
    end
  end

  // Internal fundamental reset follows either reset pin.
  assign fundamental_reset_n_active = !(perst_s2_reg && global_reset_n_s2_reg);
  assign global_reset_n_active = !global_reset_n_s2_reg;

  assign hit0 = cfg_hit(i_cfg, BCDR_DIAG0_OFS);
  assign hit1 = cfg_hit(i_cfg, BCDR_DIAG1_OFS);
  assign rd_strobe = i_cfg.req && !i_cfg.we;

  // Next value of the first diagnostic register.
  always_comb begin
    logic [31:0] v;
    v = diag0_reg;
    if (hit0 && i_cfg.we) begin
      v = be_write(v, i_cfg.wdata, i_cfg.be, BCDR_DIAG0_WMASK);
    end
    if (fundamental_reset_n_active) begin
      v = reset_fields(v, BCDR_DIAG0_RST, BCDR_DIAG0_FUNDAMENTAL_RESET_N_MASK);
    end
    if (global_reset_n_active) begin
      v = reset_fields(v, BCDR_DIAG0_RST, BCDR_DIAG0_GLOBAL_RESET_N_MASK);
    end
    diag0_next = bcdr_diag0_t'(v);
  end

  // Next value of the second diagnostic register.
  always_comb begin
    logic [31:0] v;
    v = diag1_reg;
    if (hit1 && i_cfg.we) begin
      v = be_write(v, i_cfg.wdata, i_cfg.be, BCDR_DIAG1_WMASK);
    end
    if (fundamental_reset_n_active) begin
      v = reset_fields(v, BCDR_DIAG1_RST, BCDR_DIAG1_FUNDAMENTAL_RESET_N_MASK);
    end
    diag1_next = bcdr_diag1_t'(v);
  end

  // Power-on reset restores both registers in full.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      diag0_reg <= bcdr_diag0_t'(BCDR_DIAG0_RST);
      diag1_reg <= bcdr_diag1_t'(BCDR_DIAG1_RST);
    end else begin
      diag0_reg <= diag0_next;
      diag1_reg <= diag1_next;
    end
  end

  // Read data selected by offset; writes and unmapped offsets read zero.
  always_comb begin
    rdata_next = 32'h00000000;
    if (rd_strobe && hit0) begin
      rdata_next = diag0_reg;
    end else if (rd_strobe && hit1) begin
      rdata_next = diag1_reg;
    end
  end

  // Read data and acknowledge, one cycle after the request.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cfg_rdata <= 32'h00000000;
      o_cfg_ack <= 1'b0;
    end else begin
      o_cfg_ack <= i_cfg.req;
      o_cfg_rdata <= rdata_next;
    end
  end

  assign cl_dw = line_dw(i_cache_line_size);

  // Prefetch length in doublewords for the current upstream read.
  always_comb begin
    prefetch_next = cl_dw;
    if (i_read_prefetch_disable) begin
      if (i_burst_read) begin
        prefetch_next = BCDR_SINGLE_DW;
      end
    end else if (diag0_reg.four_line_prefetch && diag0_reg.cl_check_en &&
                 (i_read_multiple || i_force_multiple_read)) begin
      prefetch_next = 8'(cl_dw << 2);
    end else if (i_read_multiple) begin
      prefetch_next = 8'(cl_dw << 1);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_prefetch_dw <= 8'h00;
    end else begin
      o_prefetch_dw <= prefetch_next;
    end
  end

  // Free space required by the threshold setting.
  always_comb begin
    case (diag0_reg.up_thresh)
      2'h0: need_dw = 10'(cl_dw) + BCDR_THR_EXTRA_4;
      2'h1: need_dw = 10'(cl_dw) + BCDR_THR_EXTRA_8;
      2'h2: need_dw = 10'(cl_dw) + BCDR_THR_EXTRA_12;
      2'h3: need_dw = 10'(cl_dw) * 10'(BCDR_THR_2LINE) + BCDR_THR_EXTRA_4;
      default: need_dw = 10'(cl_dw) * 10'(BCDR_THR_1LINE);
    endcase
  end

  // Acceptance gate for upstream transactions.
  assign o_up_accept = i_up_req &&
    (!diag0_reg.up_thresh_en || (i_buf_free_dw >= need_dw));

  // Configuration access enable for memory-mapped registers.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cfg_mem_access_en <= 1'b0;
    end else begin
      o_cfg_mem_access_en <= diag0_reg.cfg_mem_access;
    end
  end

  // Power management disables, kept across a fundamental reset.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_dis_bridge_pme <= 1'b0;
      o_dis_ohci_pme <= 1'b0;
    end else begin
      o_dis_bridge_pme <= diag0_reg.dis_bridge_pme;
      o_dis_ohci_pme <= diag0_reg.dis_ohci_pme;
    end
  end

  // Exit latency mirror into the link capabilities field.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_link_cap_l1_exit <= 3'h0;
    end else if (i_common_clock_config) begin
      o_link_cap_l1_exit <= diag1_reg.l1_exit_async;
    end else begin
      o_link_cap_l1_exit <= diag1_reg.l1_exit_common;
    end
  end

  // Secondary bus reset passes unless masked.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_secondary_reset <= 1'b0;
    end else begin
      o_secondary_reset <= i_secondary_reset_request &&
                           !diag1_reg.secondary_reset_mask;
    end
  end

  // Timer 0 is the L1 entry timer, timer 1 the L0s entry timer.
  assign tmr_limit[0] = diag1_reg.l1_entry_timer;
  assign tmr_limit[1] = diag1_reg.l0s_entry_timer;
  assign tmr_tick_len[0] = BCDR_L1_TICK_CYC;
  assign tmr_tick_len[1] = BCDR_L0S_TICK_CYC;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_tmr
      logic [2:0] div_reg;
      logic tick;
      logic [3:0] idle_reg;

      // Tick divider, restarted by traffic so ticks stay aligned.
      assign tick = (div_reg == 3'(tmr_tick_len[g] - 3'h1));

      always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          div_reg <= 3'h0;
        end else if (i_link_activity || tick) begin
          div_reg <= 3'h0;
        end else begin
          div_reg <= div_reg + 3'h1;
        end
      end

      // Idle tick count, saturating at the programmed limit.
      always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          idle_reg <= 4'h0;
        end else if (i_link_activity) begin
          idle_reg <= 4'h0;
        end else if (tick && (idle_reg < tmr_limit[g])) begin
          idle_reg <= idle_reg + 4'h1;
        end
      end

      // Entry request holds while the link stays idle.
      always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          tmr_req[g] <= 1'b0;
        end else begin
          tmr_req[g] <= !i_link_activity &&
                        (idle_reg >= tmr_limit[g]);
        end
      end
    end
  endgenerate

  assign o_l1_entry_req = tmr_req[0];
  assign o_l0s_entry_req = tmr_req[1];

endmodule

// >>> verification/bcdr_regs_monitor.sv
// Concurrent checks on the diagnostic register bank ports.
// Assumes it is bound to bcdr_regs and sees its ports only.
`timescale 1ns/1ns
module bcdr_regs_monitor
  import bcdr_pkg::*;
(
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Configuration access.
  input wire bcdr_cfg_req_t i_cfg,
  input wire logic [31:0] o_cfg_rdata,
  input wire logic o_cfg_ack,
  // Prefetch and acceptance.
  input wire logic i_read_prefetch_disable,
  input wire logic i_force_multiple_read,
  input wire logic i_read_multiple,
  input wire logic i_burst_read,
  input wire logic [7:0] i_cache_line_size,
  input wire logic [7:0] o_prefetch_dw,
  input wire logic i_up_req,
  input wire logic [9:0] i_buf_free_dw,
  input wire logic o_up_accept,
  // Reset mask and link timers.
  input wire logic i_secondary_reset_request,
  input wire logic o_secondary_reset,
  input wire logic i_link_activity,
  input wire logic o_l1_entry_req,
  input wire logic o_l0s_entry_req
);
  logic [7:0] cl;
  assign cl = (i_cache_line_size == 8'h08 || i_cache_line_size == 8'h10 ||
    i_cache_line_size == 8'h20) ? i_cache_line_size : 8'h08;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  a_ack_follows: assert property (1'h1 |=> o_cfg_ack == $past(i_cfg.req))
    else $error("ack does not follow request by one cycle");
  a_write_rdata: assert property (o_cfg_ack && $past(i_cfg.we) |->
    o_cfg_rdata == 32'h0) else $error("write ack with nonzero data");
  a_d0_ro_zero: assert property (o_cfg_ack && !$past(i_cfg.we) &&
    $past(i_cfg.addr) == BCDR_DIAG0_OFS |-> o_cfg_rdata[0] == 1'h0 &&
    o_cfg_rdata[15:8] == 8'h00) else $error("read-only diag0 bits set");
  a_d1_ro_zero: assert property (o_cfg_ack && !$past(i_cfg.we) &&
    $past(i_cfg.addr) == BCDR_DIAG1_OFS |-> o_cfg_rdata[31:21] == 11'h000)
    else $error("read-only diag1 bits set");
  a_rpd_burst_one: assert property (i_read_prefetch_disable &&
    i_burst_read |=> o_prefetch_dw == 8'h01)
    else $error("disabled burst prefetch not one dword");
  a_plain_one_line: assert property ((i_read_prefetch_disable &&
    !i_burst_read) || (!i_read_prefetch_disable && !i_read_multiple &&
    !i_force_multiple_read) |=> o_prefetch_dw == $past(cl))
    else $error("plain read prefetch not one line");
  a_accept_ample: assert property (i_up_req &&
    {1'h0, i_buf_free_dw} >= {2'h0, cl, 1'h0} + 11'h00C |-> o_up_accept)
    else $error("request refused with ample space");
  a_accept_needs: assert property (o_up_accept |-> i_up_req)
    else $error("accept without request");
  a_sec_rst_src: assert property (o_secondary_reset |->
    $past(i_secondary_reset_request)) else $error("unrequested sec reset");
  a_activity_drop: assert property (i_link_activity |=>
    !o_l0s_entry_req && !o_l1_entry_req) else $error("entry during traffic");
  a_l1_rise_idle: assert property ($rose(o_l1_entry_req) |->
    !$past(i_link_activity)) else $error("l1 entry right after traffic");
endmodule

bind bcdr_regs bcdr_regs_monitor i_mon (.*);

// >>> verification/tb.sv
// Self-checking bench for the diagnostic register bank.
// Assumes bcdr_regs and its monitor are compiled beforehand.
`timescale 1ns/1ns
module tb;
  import bcdr_pkg::*;
  logic i_mclk = 1'h0, i_rst_b = 1'h0;
  logic i_pcie_rst_b = 1'h1, i_global_reset_n = 1'h1;
  bcdr_cfg_req_t i_cfg = '0;
  logic i_force_multiple_read = 1'h0, i_read_prefetch_disable = 1'h0;
  logic i_read_multiple = 1'h0, i_burst_read = 1'h0, i_up_req = 1'h0;
  logic [7:0] i_cache_line_size = 8'h10;
  logic [9:0] i_buf_free_dw = 10'h000;
  logic i_common_clock_config = 1'h0, i_secondary_reset_request = 1'h0;
  logic i_link_activity = 1'h0;
  logic [31:0] o_cfg_rdata, rd;
  logic [7:0] o_prefetch_dw;
  logic [2:0] o_link_cap_l1_exit;
  logic o_cfg_ack, o_up_accept, o_cfg_mem_access_en, o_secondary_reset;
  logic o_dis_bridge_pme, o_dis_ohci_pme, o_l1_entry_req, o_l0s_entry_req;
  logic [9:0] need;
  logic [19:0] pt [6] = '{20'hC0C01, 20'hC0810, 20'hC0140, 20'hC0240,
    20'h40220, 20'hC0010};
  int err_count = 0, cmp_count = 0, cyc = 0;

  always #50 i_mclk = ~i_mclk;
  bcdr_regs i_dut (.*);

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  // One access: request for one cycle, data taken with the ack.
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [3:0] b, input logic [31:0] d);
    @(posedge i_mclk) i_cfg <= '{1'h1, w, a, b, d};
    @(posedge i_mclk) i_cfg.req <= 1'h0;
    #1 rd = o_cfg_rdata;
    chk("ack", 32'h1, {31'h0, o_cfg_ack});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'h1, a, 4'hF, d);
  endtask

  task automatic rdc(input string n, input logic [7:0] a,
                     input logic [31:0] e);
    acc(1'h0, a, 4'hF, 32'h0);
    chk(n, e, rd);
  endtask

  task automatic thr(input logic [9:0] f, input logic e);
    @(posedge i_mclk) i_buf_free_dw <= f;
    tick(1);
    chk("accept", {31'h0, e}, {31'h0, o_up_accept});
  endtask

  initial begin
    tick(16);
    @(posedge i_mclk) i_rst_b <= 1'h1;
    tick(3);
    rdc("diag0", 8'hC0, 32'h0);
    rdc("diag1", 8'hC4, 32'h00120108);
    chk("mirror", 32'h4, 32'(o_link_cap_l1_exit));
    wr(8'hC0, 32'hFFFFFFFF);
    rdc("diag0", 8'hC0, 32'h000300FE);
    chk("cfgmem", 32'h1, 32'(o_cfg_mem_access_en));
    chk("pme", 32'h3, 32'({o_dis_bridge_pme, o_dis_ohci_pme}));
    acc(1'h1, 8'hC0, 4'h1, 32'h0);
    rdc("diag0", 8'hC0, 32'h00030000);
    chk("cfgmem", 32'h0, 32'(o_cfg_mem_access_en));
    wr(8'hC4, 32'hFFFFFFFF);
    rdc("diag1", 8'hC4, 32'h001FFFFF);
    wr(8'hC8, 32'hFFFFFFFF);
    rdc("unmapped", 8'hC8, 32'h0);
    wr(8'hC4, 32'h00150108);
    @(posedge i_mclk) i_common_clock_config <= 1'h1;
    tick(2);
    chk("mirror", 32'h5, 32'(o_link_cap_l1_exit));
    @(posedge i_mclk) i_common_clock_config <= 1'h0;
    tick(2);
    chk("mirror", 32'h2, 32'(o_link_cap_l1_exit));
    @(posedge i_mclk) i_secondary_reset_request <= 1'h1;
    tick(2);
    chk("secrst", 32'h1, 32'(o_secondary_reset));
    wr(8'hC4, 32'h00150508);
    tick(1);
    chk("secrst", 32'h0, 32'(o_secondary_reset));
    @(posedge i_mclk) i_up_req <= 1'h1;
    thr(10'h000, 1'h1);
    for (int f = 0; f < 4; f++) begin
      wr(8'hC0, 32'h8 | (f << 4));
      need = (f == 3) ? 10'h024 : 10'(20 + 4 * f);
      thr(need - 10'h001, 1'h0);
      thr(need, 1'h1);
    end
    thr(10'h030, 1'h1);
    @(posedge i_mclk) i_cache_line_size <= 8'h0C;
    wr(8'hC0, 32'h8);
    thr(10'h00B, 1'h0);
    thr(10'h00C, 1'h1);
    @(posedge i_mclk) i_cache_line_size <= 8'h10;
    for (int i = 0; i < 6; i++) begin
      wr(8'hC0, {24'h0, pt[i][19:12]});
      @(posedge i_mclk) {i_read_prefetch_disable, i_burst_read,
        i_read_multiple, i_force_multiple_read} <= pt[i][11:8];
      tick(2);
      chk("pref", {24'h0, pt[i][7:0]}, 32'(o_prefetch_dw));
    end
    @(posedge i_mclk) i_link_activity <= 1'h1;
    @(posedge i_mclk) i_link_activity <= 1'h0;
    tick(2);
    chk("l0s", 32'h0, 32'(o_l0s_entry_req));
    tick(1);
    chk("l0s", 32'h1, 32'(o_l0s_entry_req));
    tick(21);
    chk("l1", 32'h0, 32'(o_l1_entry_req));
    tick(1);
    chk("l1", 32'h1, 32'(o_l1_entry_req));
    wr(8'hC0, 32'h000300FC);
    @(posedge i_mclk) i_pcie_rst_b <= 1'h0;
    tick(4);
    @(posedge i_mclk) i_pcie_rst_b <= 1'h1;
    tick(4);
    rdc("diag0", 8'hC0, 32'h00030080);
    rdc("diag1", 8'hC4, 32'h00120108);
    chk("cfgmem", 32'h0, 32'(o_cfg_mem_access_en));
    chk("pme", 32'h3, 32'({o_dis_bridge_pme, o_dis_ohci_pme}));
    @(posedge i_mclk) i_global_reset_n <= 1'h0;
    tick(4);
    @(posedge i_mclk) i_global_reset_n <= 1'h1;
    tick(4);
    rdc("diag0", 8'hC0, 32'h00000080);
    chk("pme", 32'h0, 32'({o_dis_bridge_pme, o_dis_ohci_pme}));
    end_of_test();
  end
endmodule
